// ==== hdl/hbu_baud.sv ====
// Fractional divider making the sixteen-per-bit sampling tick.
// Assumes the increment is a static register value from the same clock domain.
module hbu_baud #(
  parameter int ACC_W = 24
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ACC_W-1:0] inc,
  output logic tick
);
  logic [ACC_W:0] acc_q;
  logic [ACC_W:0] sum;

  // The carry out of the accumulator is the tick; its jitter is one clock at most.
  assign sum = {1'b0, acc_q[ACC_W-1:0]} + {1'b0, inc};
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      acc_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      acc_q <= sum;
      tick <= sum[ACC_W];
    end
  end
endmodule // hbu_baud

// ==== hdl/hbu_pkg.sv ====
// Package of the host serial port: addresses, fields, reset values, timing.
// Assumes a single 40 MHz clock and an APB master with 32-bit data.
package hbu_pkg;
  // ================
  // Clock and rate figures.
  // ================
  localparam longint CLK_HZ = 40_000_000;
  localparam longint BAUD_MIN = 1200;
  localparam longint BAUD_MAX = 1_500_000;
  localparam longint BAUD_DEF = 9600;
  localparam int OVS = 16;
  localparam int ACC_W = 24;
  // Phase increment for sixteen ticks per bit: baud * 16 * 2^24 / clock.
  localparam logic [23:0] INC_DEF = 24'(BAUD_DEF * OVS * (longint'(1) << ACC_W) / CLK_HZ);
  // ================
  // Frame and break timing in sampling ticks.
  // ================
  localparam int FRAME_BITS = 12;
  localparam logic [15:0] FRAME_TICKS = 16'(FRAME_BITS * OVS);
  localparam logic [7:0] TX_BRK_TICKS = 8'(13 * OVS);
  localparam logic [7:0] TX_GAP_TICKS = 8'(2 * OVS);
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] END_TICK = 4'hf;
  localparam logic [15:0] THR_DEF = 16'h0000;
  // ================
  // Register byte addresses.
  // ================
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INC = 8'h04;
  localparam logic [7:0] ADDR_THR = 8'h08;
  localparam logic [7:0] ADDR_TXD = 8'h0c;
  localparam logic [7:0] ADDR_RXD = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_ISTAT = 8'h18;
  localparam logic [7:0] ADDR_IMASK = 8'h1c;
  localparam logic [7:0] ADDR_BLEN = 8'h20;
  // ================
  // Control fields.
  // ================
  localparam int CTRL_SEND_BRK = 6;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  typedef struct packed {
    logic transport_en;
    logic brk_wake_en;
    logic flow_en;
    logic stop2;
    logic [1:0] parity;
  } hbu_ctrl_t;
  localparam hbu_ctrl_t CTRL_DEF = '{transport_en: 1'b0, brk_wake_en: 1'b0, flow_en: 1'b0,
                                     stop2: 1'b0, parity: PAR_NONE};
  // ================
  // Interrupt bits.
  // ================
  localparam int NIRQ = 7;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_BRK = 2;
  localparam int IRQ_PAR = 3;
  localparam int IRQ_FRM = 4;
  localparam int IRQ_OVR = 5;
  localparam int IRQ_RST = 6;
  localparam logic [6:0] IMASK_DEF = 7'h00;
endpackage

// ==== hdl/hbu_uart.sv ====
// Host serial port with break detection, break reset, boot hold and break transmit.
// Assumes one 40 MHz clock, an APB master and unsynchronised serial pins.
// Function
// - Transmit line out, receive line in, asynchronous.
// - Optional active-low request and clear handshake.
// - Programmable rate, 1200 baud to 1.5 megabaud.
// - Eight data bits, selectable parity, one/two stops.
// - Break is receive low beyond one frame.
// - Break longer than threshold resets the module.
// - Break at boot holds low power state.
// - Transmitter sends wake break when enabled.
// - Transport mode sends break before data when wake break is enabled.
//
// Local design decisions: the APB slave port and the register offsets.
module hbu_uart (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd,
  output logic rts_n,
  output logic irq,
  output logic low_power,
  output logic hw_reset
);
  // ================
  // Declarations.
  // ================
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100, RX_PAR = 5'b01000, RX_STOP = 5'b10000
  } hbu_rx_t;
  typedef enum logic [6:0] {
    TX_IDLE = 7'b0000001, TX_BRK = 7'b0000010, TX_GAP = 7'b0000100, TX_START = 7'b0001000,
    TX_DATA = 7'b0010000, TX_PAR = 7'b0100000, TX_STOP = 7'b1000000
  } hbu_tx_t;
  hbu_pkg::hbu_ctrl_t ctrl_q;
  logic [23:0] inc_q;
  logic [15:0] thr_q;
  logic [15:0] blen_q;
  logic [15:0] low_cnt_q;
  logic [1:0] rx_sync_q;
  logic [1:0] cts_sync_q;
  logic tick;
  hbu_rx_t rx_st_q;
  logic [3:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_buf_q;
  logic rx_valid_q;
  hbu_tx_t tx_st_q;
  logic [3:0] tx_cnt_q;
  logic [7:0] tx_long_q;
  logic [2:0] tx_bit_q;
  logic tx_stop2_q;
  logic [7:0] tx_sh_q;
  logic [7:0] tx_buf_q;
  logic tx_pend_q;
  logic brk_req_q;
  logic brk_seen_q;
  logic reset_fired_q;
  logic [6:0] istat_q;
  logic [6:0] imask_q;
  logic [6:0] ev;
  logic acc;
  logic wr;
  logic rd;
  logic rxs;
  logic cts_ok;
  logic run;

  // Parity bit for a byte under the selected mode.
  function automatic logic par_bit(input logic [1:0] mode, input logic [7:0] d);
    par_bit = (mode == hbu_pkg::PAR_ODD) ? ~^d : ^d;
  endfunction

  // A mode with a parity bit in the frame.
  function automatic logic has_par(input logic [1:0] mode);
    has_par = (mode == hbu_pkg::PAR_ODD) || (mode == hbu_pkg::PAR_EVEN);
  endfunction

  // ================
  // Pin synchronisers.
  // ================
  // Receive resets low so that the boot check sees a line that is really high before it lets go.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rx_sync_q <= 2'b00;
      cts_sync_q <= 2'b11;
    end
    else
    begin
      rx_sync_q <= {rx_sync_q[0], rxd};
      cts_sync_q <= {cts_sync_q[0], cts_n};
    end
  end
  assign rxs = rx_sync_q[1];
  assign cts_ok = ~ctrl_q.flow_en | ~cts_sync_q[1];
  assign run = ~low_power;

  hbu_baud #(
    .ACC_W(hbu_pkg::ACC_W)
  ) u_baud (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inc(inc_q),
    .tick(tick)
  );

  // ================
  // APB slave.
  // ================
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;

  // One wait state: the answer comes in the second access cycle.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready)
      begin
        prdata <= '0;
        case (paddr)
          hbu_pkg::ADDR_CTRL: prdata <= {26'h000_0000, ctrl_q};
          hbu_pkg::ADDR_INC: prdata <= {8'h00, inc_q};
          hbu_pkg::ADDR_THR: prdata <= {16'h0000, thr_q};
          hbu_pkg::ADDR_TXD: prdata <= {24'h00_0000, tx_buf_q};
          hbu_pkg::ADDR_RXD: prdata <= {24'h00_0000, rx_buf_q};
          hbu_pkg::ADDR_STAT: prdata <= {26'h000_0000, rxs, low_power, tx_st_q != TX_IDLE,
                                         tx_pend_q, brk_seen_q, rx_valid_q};
          hbu_pkg::ADDR_ISTAT: prdata <= {25'h000_0000, istat_q};
          hbu_pkg::ADDR_IMASK: prdata <= {25'h000_0000, imask_q};
          hbu_pkg::ADDR_BLEN: prdata <= {16'h0000, blen_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= hbu_pkg::CTRL_DEF;
      inc_q <= hbu_pkg::INC_DEF;
      thr_q <= hbu_pkg::THR_DEF;
      imask_q <= hbu_pkg::IMASK_DEF;
    end
    else if (wr)
    begin
      case (paddr)
        hbu_pkg::ADDR_CTRL: ctrl_q <= pwdata[5:0];
        hbu_pkg::ADDR_INC: inc_q <= pwdata[23:0];
        hbu_pkg::ADDR_THR: thr_q <= pwdata[15:0];
        hbu_pkg::ADDR_IMASK: imask_q <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // ================
  // Boot hold.
  // ================
  // Held from reset until the receive line is seen high; only a new reset brings it back.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      low_power <= 1'b1;
    else if (rxs)
      low_power <= 1'b0;
  end

  // ================
  // Break detector and break reset.
  // ================
  // The low-time counter saturates rather than wraps; the fired flag keeps a very long break from firing twice.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      low_cnt_q <= '0;
      blen_q <= '0;
      brk_seen_q <= 1'b0;
      reset_fired_q <= 1'b0;
      hw_reset <= 1'b0;
    end
    else
    begin
      hw_reset <= 1'b0;
      if (rxs | low_power)
      begin
        if (brk_seen_q)
          blen_q <= low_cnt_q;
        low_cnt_q <= '0;
        brk_seen_q <= 1'b0;
        reset_fired_q <= 1'b0;
      end
      else if (tick)
      begin
        if (low_cnt_q != 16'hffff)
          low_cnt_q <= low_cnt_q + 16'h0001;
        if (low_cnt_q > hbu_pkg::FRAME_TICKS)
          brk_seen_q <= 1'b1;
        if ((thr_q != 16'h0000) && (low_cnt_q > thr_q) && ~reset_fired_q)
        begin
          hw_reset <= 1'b1;
          reset_fired_q <= 1'b1;
        end
      end
    end
  end

  // ================
  // Receiver.
  // ================
  // Start is checked mid-bit, data and stop one bit later each; only the first stop is checked.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_buf_q <= '0;
    end
    else if (~run)
      rx_st_q <= RX_IDLE;
    else if (tick)
    begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      case (rx_st_q)
        RX_IDLE:
        begin
          rx_cnt_q <= '0;
          if (~rxs)
            rx_st_q <= RX_START;
        end
        RX_START:
        begin
          if (rx_cnt_q == hbu_pkg::MID_TICK)
          begin
            rx_cnt_q <= '0;
            rx_bit_q <= '0;
            rx_st_q <= rxs ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_cnt_q == hbu_pkg::END_TICK)
          begin
            rx_sh_q <= {rxs, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7)
              rx_st_q <= has_par(ctrl_q.parity) ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR:
        begin
          if (rx_cnt_q == hbu_pkg::END_TICK)
            rx_st_q <= RX_STOP;
        end
        RX_STOP:
        begin
          if (rx_cnt_q == hbu_pkg::END_TICK)
          begin
            rx_buf_q <= rx_sh_q;
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Interrupt events (receive, transmit, break, parity, framing, overrun, reset), each a one-cycle pulse.
  always_comb
  begin
    ev = '0;
    ev[hbu_pkg::IRQ_RX] = tick & run & (rx_st_q == RX_STOP) & (rx_cnt_q == hbu_pkg::END_TICK) & rxs;
    ev[hbu_pkg::IRQ_FRM] = tick & run & (rx_st_q == RX_STOP) & (rx_cnt_q == hbu_pkg::END_TICK) & ~rxs;
    ev[hbu_pkg::IRQ_PAR] = tick & run & (rx_st_q == RX_PAR) & (rx_cnt_q == hbu_pkg::END_TICK)
                           & (rxs != par_bit(ctrl_q.parity, rx_sh_q));
    ev[hbu_pkg::IRQ_OVR] = ev[hbu_pkg::IRQ_RX] & rx_valid_q & ~(rd && paddr == hbu_pkg::ADDR_RXD);
    ev[hbu_pkg::IRQ_TX] = tick & (tx_st_q == TX_STOP) & (tx_cnt_q == hbu_pkg::END_TICK) & ~tx_stop2_q;
    ev[hbu_pkg::IRQ_BRK] = tick & ~rxs & run & ~brk_seen_q & (low_cnt_q > hbu_pkg::FRAME_TICKS);
    ev[hbu_pkg::IRQ_RST] = hw_reset;
  end

  // Holding flag: a new byte wins over a read that clears it in the same cycle.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rx_valid_q <= 1'b0;
    else if (ev[hbu_pkg::IRQ_RX])
      rx_valid_q <= 1'b1;
    else if (rd && paddr == hbu_pkg::ADDR_RXD)
      rx_valid_q <= 1'b0;
  end

  // Request-to-send is active low, asserted with flow control off except during the boot hold.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rts_n <= 1'b1;
    else
      rts_n <= low_power | (ctrl_q.flow_en & rx_valid_q);
  end

  // ================
  // Transmit holding register and break request.
  // ================
  // A write while a byte is pending is dropped; software polls the pending bit first.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tx_buf_q <= '0;
      tx_pend_q <= 1'b0;
      brk_req_q <= 1'b0;
    end
    else
    begin
      if (wr && paddr == hbu_pkg::ADDR_TXD && ~tx_pend_q)
      begin
        tx_buf_q <= pwdata[7:0];
        tx_pend_q <= 1'b1;
      end
      else if (tick && tx_st_q == TX_START && tx_cnt_q == 4'h0)
        tx_pend_q <= 1'b0;
      if (wr && paddr == hbu_pkg::ADDR_CTRL && pwdata[hbu_pkg::CTRL_SEND_BRK])
        brk_req_q <= 1'b1;
      else if (tx_st_q == TX_BRK)
        brk_req_q <= 1'b0;
    end
  end

  // ================
  // Transmitter.
  // ================
  // Data that follows a stop bit directly skips the wake break, so only a start from idle pays it.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_long_q <= '0;
      tx_bit_q <= '0;
      tx_stop2_q <= 1'b0;
      tx_sh_q <= '0;
      txd <= 1'b1;
    end
    else if (~run)
    begin
      tx_st_q <= TX_IDLE;
      txd <= 1'b1;
    end
    else if (tick)
    begin
      tx_cnt_q <= tx_cnt_q + 4'h1;
      case (tx_st_q)
        TX_IDLE:
        begin
          tx_cnt_q <= '0;
          tx_long_q <= '0;
          txd <= 1'b1;
          if (brk_req_q && ctrl_q.brk_wake_en)
            tx_st_q <= TX_BRK;
          else if (tx_pend_q && cts_ok)
            tx_st_q <= (ctrl_q.transport_en && ctrl_q.brk_wake_en) ? TX_BRK : TX_START;
        end
        TX_BRK:
        begin
          txd <= 1'b0;
          tx_long_q <= tx_long_q + 8'h01;
          if (tx_long_q == hbu_pkg::TX_BRK_TICKS - 8'h01)
          begin
            tx_long_q <= '0;
            tx_st_q <= TX_GAP;
          end
        end
        TX_GAP:
        begin
          txd <= 1'b1;
          tx_long_q <= tx_long_q + 8'h01;
          tx_cnt_q <= '0;
          if (tx_long_q == hbu_pkg::TX_GAP_TICKS - 8'h01)
            tx_st_q <= (tx_pend_q && cts_ok) ? TX_START : TX_IDLE;
        end
        TX_START:
        begin
          txd <= 1'b0;
          if (tx_cnt_q == 4'h0)
            tx_sh_q <= tx_buf_q;
          if (tx_cnt_q == hbu_pkg::END_TICK)
          begin
            tx_bit_q <= '0;
            tx_st_q <= TX_DATA;
          end
        end
        TX_DATA:
        begin
          txd <= tx_sh_q[tx_bit_q];
          if (tx_cnt_q == hbu_pkg::END_TICK)
          begin
            tx_bit_q <= tx_bit_q + 3'h1;
            tx_stop2_q <= ctrl_q.stop2;
            if (tx_bit_q == 3'h7)
              tx_st_q <= has_par(ctrl_q.parity) ? TX_PAR : TX_STOP;
          end
        end
        TX_PAR:
        begin
          txd <= par_bit(ctrl_q.parity, tx_sh_q);
          if (tx_cnt_q == hbu_pkg::END_TICK)
            tx_st_q <= TX_STOP;
        end
        TX_STOP:
        begin
          txd <= 1'b1;
          if (tx_cnt_q == hbu_pkg::END_TICK)
          begin
            if (tx_stop2_q)
              tx_stop2_q <= 1'b0;
            else if (tx_pend_q && cts_ok)
              tx_st_q <= TX_START;
            else
              tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ================
  // Interrupts.
  // ================
  // Write one to clear; an event in the same cycle keeps its bit set.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      istat_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && paddr == hbu_pkg::ADDR_ISTAT)
        istat_q <= (istat_q & ~pwdata[6:0]) | ev;
      else
        istat_q <= istat_q | ev;
      irq <= |(istat_q & imask_q);
    end
  end
endmodule // hbu_uart

// ==== verif/hbu_host_model.sv ====
// Model of the host at the far end of the serial line.
// Assumes the bit time is a whole number of module clock cycles.
module hbu_host_model #(
  parameter int BIT_CYC = 40
) (
  input wire logic mclk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ================
  // Line drivers
  // ================
  // The line starts low, so the module powers up into its boot hold.
  initial
  begin
    rxd = 1'b0;
    cts_n = 1'b0;
  end

  // Drive a level for a number of cycles.
  task hold(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge mclk);
  endtask

  // Release the line to its idle high level.
  task idle();
    @(posedge mclk);
    rxd <= 1'b1;
  endtask

  // Permission to send is active low.
  task set_cts(input logic v);
    @(posedge mclk);
    cts_n <= v;
  endtask

  // One frame, least significant bit first, with an optional wrong parity.
  task send(input logic [7:0] b, input logic [1:0] par, input logic stop2, input logic bad);
    int i;
    @(posedge mclk);
    hold(1'b0, BIT_CYC);
    for (i = 0; i < 8; i++)
      hold(b[i], BIT_CYC);
    if (par != 2'h0)
      hold((par == 2'h1 ? ~^b : ^b) ^ bad, BIT_CYC);
    hold(1'b1, stop2 ? 2 * BIT_CYC : BIT_CYC);
  endtask

  // A long low, then one idle bit.
  task brk(input int bits);
    @(posedge mclk);
    hold(1'b0, bits * BIT_CYC);
    hold(1'b1, BIT_CYC);
  endtask

  // Sample ten bit times after a start edge, each in mid bit.
  task recv(output logic [9:0] s);
    int i;
    @(posedge mclk);
    while (txd !== 1'b0)
      @(posedge mclk);
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (i = 0; i < 10; i++)
    begin
      repeat (BIT_CYC) @(posedge mclk);
      s[i] = txd;
    end
  endtask

  // Length of the next low stretch in cycles.
  task lowlen(output int n);
    @(posedge mclk);
    while (txd !== 1'b0)
      @(posedge mclk);
    n = 0;
    while (txd === 1'b0)
    begin
      n++;
      @(posedge mclk);
    end
  endtask
endmodule // hbu_host_model

// ==== verif/hbu_uart_props.sv ====
// Checker for the host serial port: bus timing, boot hold and break reset seen at the ports.
// Assumes the bind below, one clock and a synchronous reset.
module hbu_uart_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic irq,
  input wire logic low_power,
  input wire logic hw_reset
);
  // ================
  // Properties
  // ================
  // All checks share the one clock; reset silences them.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Outputs leave reset idle, with the boot hold in force.
  AST_RST_IDLE: assert property ($fell(sys_rst) |-> txd && rts_n && low_power
    && !irq && !hw_reset && !pready) else $error("outputs not idle after reset");
  // One wait state: the answer comes in the second access cycle.
  AST_PREADY_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("bus answer not one wait state");
  // The answer stands for a single cycle.
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  // An error flag only ever rides on an answer.
  AST_SLVERR_PAIR: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  // Places past the map are refused and read as zero.
  AST_UNMAPPED: assert property (psel && penable && pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  // A line held low keeps the module asleep.
  AST_LP_HOLD: assert property (low_power && !rxd && !$past(rxd) && !$past(rxd, 2) && !$past(rxd, 3)
    |=> low_power) else $error("boot hold left while line low");
  // The host is told not to send while the module sleeps.
  AST_LP_RTS: assert property (low_power |-> rts_n)
    else $error("ready to receive during boot hold");
  // The reset request is a single pulse.
  AST_HWRST_PULSE: assert property (hw_reset |=> !hw_reset)
    else $error("reset pulse too long");
  // A reset request needs the line to have been low just before.
  AST_HWRST_LOW: assert property (hw_reset |-> !$past(rxd, 3) || !$past(rxd, 4))
    else $error("reset pulse without a low line");
endmodule // hbu_uart_props

bind hbu_uart hbu_uart_props hbu_uart_props_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .rts_n(rts_n),
  .irq(irq), .low_power(low_power), .hw_reset(hw_reset));

// ==== verif/hbu_uart_tb.sv ====
// Self-checking bench for the host serial port: register bus, serial frames, breaks.
// Assumes the host model and the bound checker; the line runs at one megabaud.
module hbu_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, rxd, cts_n, txd, rts_n, irq, low_power, hw_reset;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] s;
  logic [1:0] par;
  logic err;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int hw_cnt = 0;
  int m, n;

  hbu_uart hbu_uart_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .cts_n(cts_n), .txd(txd), .rts_n(rts_n), .irq(irq), .low_power(low_power), .hw_reset(hw_reset));
  hbu_host_model hbu_host_model_i (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));

  // ================
  // Clock, watchdog and pulse count
  // ================
  // A 25 ns clock.
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Cycle count; a hang is cut off well past the expected run length.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (hw_reset === 1'b1)
      hw_cnt <= hw_cnt + 1;
    if (cyc == 80000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // ================
  // Tasks
  // ================
  // Count a comparison and report a mismatch.
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  // One bus transfer; the request holds until ready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a register and compare it.
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  // Poll a status bit with a bounded number of reads.
  task poll(input int k);
    int i;
    rd = 32'h0000_0000;
    for (i = 0; i < 400 && rd[k] !== 1'b1; i++)
      apb(1'b0, hbu_pkg::ADDR_ISTAT, 32'h0000_0000);
    chk("status bit", 32'h0000_0001, {31'h0, rd[k]});
  endtask

  // Print counts and the verdict, then stop.
  task end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ================
  // Tests
  // ================
  // Every scenario runs in sequence from one reset.
  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rd = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (40) @(posedge mclk);
    chk("low_power", 32'h1, {31'h0, low_power});
    chk("rts_n", 32'h1, {31'h0, rts_n});
    rdc("ctrl", hbu_pkg::ADDR_CTRL, 32'h0000_0000);
    rdc("inc", hbu_pkg::ADDR_INC, {8'h0, hbu_pkg::INC_DEF});
    rdc("thr", hbu_pkg::ADDR_THR, 32'h0000_0000);
    rdc("imask", hbu_pkg::ADDR_IMASK, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("pslverr", 32'h1, {31'h0, err});
    hbu_host_model_i.idle();
    repeat (5) @(posedge mclk);
    chk("low_power", 32'h0, {31'h0, low_power});
    apb(1'b1, hbu_pkg::ADDR_INC, 32'h0066_6666);
    $display("test boot and registers done");
    // Each parity and stop setting, received then sent back.
    for (m = 0; m < 6; m++)
    begin
      par = 2'(m % 3);
      b = 8'hc5 ^ 8'(m * 37);
      apb(1'b1, hbu_pkg::ADDR_CTRL, {29'h0, m > 2, par});
      hbu_host_model_i.send(b, par, m > 2, 1'b0);
      poll(hbu_pkg::IRQ_RX);
      chk("parity error", 32'h0, {31'h0, rd[hbu_pkg::IRQ_PAR]});
      rdc("rx byte", hbu_pkg::ADDR_RXD, {24'h0, b});
      apb(1'b1, hbu_pkg::ADDR_ISTAT, 32'h0000_007f);
      apb(1'b1, hbu_pkg::ADDR_TXD, {24'h0, b});
      hbu_host_model_i.recv(s);
      chk("tx byte", {24'h0, b}, {24'h0, s[7:0]});
      chk("tx bit8", par == 2'h0 ? 32'h1 : {31'h0, par == 2'h1 ? ~^b : ^b}, {31'h0, s[8]});
      chk("tx bit9", 32'h1, {31'h0, s[9]});
    end
    $display("test frame formats done");
    // Bad parity still raises a masked then unmasked interrupt.
    apb(1'b1, hbu_pkg::ADDR_CTRL, {30'h0, hbu_pkg::PAR_EVEN});
    hbu_host_model_i.send(8'h3c, hbu_pkg::PAR_EVEN, 1'b0, 1'b1);
    poll(hbu_pkg::IRQ_PAR);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, hbu_pkg::ADDR_IMASK, 32'h0000_0008);
    repeat (3) @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, hbu_pkg::ADDR_ISTAT, 32'h0000_007f);
    repeat (3) @(posedge mclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, hbu_pkg::ADDR_IMASK, 32'h0000_0000);
    apb(1'b0, hbu_pkg::ADDR_RXD, 32'h0000_0000);
    $display("test parity and interrupt done");
    // Flow control both ways.
    apb(1'b1, hbu_pkg::ADDR_CTRL, 32'h0000_0008);
    hbu_host_model_i.send(8'h96, hbu_pkg::PAR_NONE, 1'b0, 1'b0);
    poll(hbu_pkg::IRQ_RX);
    chk("rts_n full", 32'h1, {31'h0, rts_n});
    rdc("rx byte", hbu_pkg::ADDR_RXD, 32'h0000_0096);
    repeat (3) @(posedge mclk);
    chk("rts_n free", 32'h0, {31'h0, rts_n});
    hbu_host_model_i.set_cts(1'b1);
    apb(1'b1, hbu_pkg::ADDR_TXD, 32'h0000_0069);
    repeat (400) @(posedge mclk);
    chk("txd held", 32'h1, {31'h0, txd});
    hbu_host_model_i.set_cts(1'b0);
    hbu_host_model_i.recv(s);
    chk("tx byte", 32'h0000_0069, {24'h0, s[7:0]});
    $display("test flow control done");
    // Break sent on request, then ahead of data in transport mode.
    apb(1'b1, hbu_pkg::ADDR_CTRL, 32'h0000_0050);
    hbu_host_model_i.lowlen(n);
    chk("break length", 32'h1, {31'h0, n >= 516 && n <= 524});
    repeat (100) @(posedge mclk);
    apb(1'b1, hbu_pkg::ADDR_CTRL, 32'h0000_0030);
    apb(1'b1, hbu_pkg::ADDR_TXD, 32'h0000_0081);
    hbu_host_model_i.lowlen(n);
    chk("wake break", 32'h1, {31'h0, n >= 516 && n <= 524});
    hbu_host_model_i.recv(s);
    chk("tx after break", 32'h0000_0081, {24'h0, s[7:0]});
    $display("test break transmit done");
    // Short low is no break; two breaks under the threshold do not add up.
    apb(1'b1, hbu_pkg::ADDR_THR, 32'h0000_0140);
    apb(1'b1, hbu_pkg::ADDR_ISTAT, 32'h0000_007f);
    hbu_host_model_i.brk(10);
    apb(1'b0, hbu_pkg::ADDR_ISTAT, 32'h0000_0000);
    chk("no break", 32'h0, {31'h0, rd[hbu_pkg::IRQ_BRK]});
    hbu_host_model_i.brk(15);
    poll(hbu_pkg::IRQ_BRK);
    hbu_host_model_i.brk(15);
    chk("no reset", 32'h0, 32'(hw_cnt));
    hbu_host_model_i.brk(30);
    chk("reset pulse", 32'h1, 32'(hw_cnt));
    $display("test break receive done");
    // Reset again mid-run: the boot hold returns.
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("low_power", 32'h1, {31'h0, low_power});
    rdc("thr", hbu_pkg::ADDR_THR, 32'h0000_0000);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule // hbu_uart_tb
